//--- irs_bus_partner.sv
// open-drain two-wire bus with pull-ups plus one rival party
// assumes enables are high while a party pulls its line low
`timescale 1ns/1ps
`default_nettype none
module irs_bus_partner (
  input  wire logic linkClk, sclOe, sdaOe, holdSda, pullScl,
  output logic      sclLine, sdaLine
);
  logic sclHoldQ = 1'h0;
  // a rival master's clock pull moves only on its own clock; its data hold is not clocked
  always @(posedge linkClk) sclHoldQ <= pullScl;
  assign sclLine = !(sclOe || sclHoldQ);
  assign sdaLine = !(sdaOe || (holdSda && !sclOe));
endmodule // irs_bus_partner
`default_nettype wire

//--- irs_defs.vh
// irs_defs.vh: offsets, field positions, a lock mask and reset values for the repeated-start sequencer
// assumes a 32-bit apb register bus; each register takes one aligned word
`ifndef IRS_DEFS_VH
`define IRS_DEFS_VH
`define IRS_OFF_BUF      8'h00
`define IRS_OFF_RELOAD   8'h04
`define IRS_OFF_MASKADR  8'h08
`define IRS_OFF_CTRL1    8'h0C
`define IRS_OFF_CTRL2    8'h10
`define IRS_OFF_STATUS   8'h14
`define IRS_OFF_IRQSTAT  8'h18
`define IRS_OFF_IRQMASK  8'h1C
`define IRS_CTRL1_WRITE_COLLISION_FLAG   7
`define IRS_CTRL2_REPEATED_START_REQUEST   1
`define IRS_CTRL2_LOWMSK 8'h1F
`define IRS_STAT_START   3
`define IRS_IRQ_DONE     0
`define IRS_IRQ_BCOL     1
`define IRS_IRQ_WRITE_COLLISION_FLAG     2
`define IRS_RST_RELOAD   8'h09
`define IRS_RST_BYTE     8'h00
`endif

//--- irs_repeated_start.v
// irs_repeated_start.v: two-wire master repeated-start sequencer with apb registers and interrupt
// assumes pins are open drain, sampled through two flip-flops; bench resolves wire levels
// How it works
// - repeated start begins only when request bit 1 is set while idle
// - first step drives the clock pin low
// - clock seen low: load baud counter from reload bits 5:0 and count
// - data pin released high for one whole baud period
// - counter expired and data high: release clock pin
// - clock seen high: reload counter from reload bits 6:0 and count
// - both high one period, then data driven low one period, clock high
// - at end request bit clears, no reload, data stays low
// - start-detected status bit 3 sets on start condition at the pins
// - interrupt flag waits until the final baud period has expired
// - request written while another event is busy is ignored
// - collision if data sampled low when clock rises
// - collision if clock falls before device drives data low
// - buffer write during sequence sets write collision, buffer unchanged
// - low five control-two bits locked until sequence finishes
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "irs_defs.vh"
module irs_repeated_start #(
  parameter CNT_W = 7
) (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        sclIn,
  output reg         sclOut,
  output reg         sclOe,
  input  wire        sdaIn,
  output reg         sdaOut,
  output reg         sdaOe,
  output reg         irq
);
  localparam S_IDLE = 6'h01;
  localparam S_SCLL = 6'h02;
  localparam S_REL  = 6'h04;
  localparam S_SCLH = 6'h08;
  localparam S_HIGH = 6'h10;
  localparam S_SDAL = 6'h20;

  reg [1:0]       sclSync_q;
  reg [1:0]       sdaSync_q;
  reg             sclPrev_q;
  reg             sdaPrev_q;
  reg [5:0]       state_q;
  reg [CNT_W-1:0] baud_q;
  reg             baudRun_q;
  reg [7:0]       buf_q;
  reg [7:0]       reload_q;
  reg [7:0]       maskAdr_q;
  reg [7:0]       ctrl1_q;
  reg [7:0]       ctrl2_q;
  reg             start_q;
  reg [2:0]       irqStat_q;
  reg [2:0]       irqMask_q;
  reg             holdLow_q;
  reg             sdaLow_q;

  wire sclS = sclSync_q[1];
  wire sdaS = sdaSync_q[1];
  wire busy = (state_q != S_IDLE);
  wire wrEn = psel & penable & pwrite;
  wire rdEn = psel & ~penable & ~pwrite;
  wire expire = baudRun_q & (baud_q == {CNT_W{1'b0}});
  wire startSeen = sclS & sdaPrev_q & ~sdaS & sclPrev_q;
  wire sclRise = sclS & ~sclPrev_q;
  wire sclFall = ~sclS & sclPrev_q;
  // the clock may be seen rising after the state has already moved on to waiting for it
  wire bcol = (((state_q == S_REL) | (state_q == S_SCLH)) & sclRise & ~sdaS)
            | (((state_q == S_SCLH) | (state_q == S_HIGH)) & sclFall);
  wire wcolEv = wrEn & (paddr == `IRS_OFF_BUF) & busy;
  wire rsReq = wrEn & (paddr == `IRS_OFF_CTRL2) & pwdata[`IRS_CTRL2_REPEATED_START_REQUEST] & ~busy;
  wire doneEv = (state_q == S_SDAL) & expire;
  wire [2:0] irqSet = {wcolEv, bcol, doneEv};
  wire [2:0] irqClr = (wrEn & (paddr == `IRS_OFF_IRQSTAT)) ? pwdata[2:0] : 3'h0;

  // two flops before any logic looks at the pins
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclSync_q <= {sclSync_q[0], sclIn};
      sdaSync_q <= {sdaSync_q[0], sdaIn};
      sclPrev_q <= sclS;
      sdaPrev_q <= sdaS;
    end
  end

  // next values of every register; the flops below only copy them
  reg [5:0]        state_d;
  reg [CNT_W-1:0]  baud_d;
  reg              baudRun_d;
  reg              holdLow_d;
  reg              sdaLow_d;
  reg [7:0]        buf_d;
  reg [7:0]        reload_d;
  reg [7:0]        maskAdr_d;
  reg [7:0]        ctrl1_d;
  reg [7:0]        ctrl2_d;
  reg              start_d;
  reg [2:0]        irqStat_d;
  reg [2:0]        irqMask_d;
  reg [31:0]       rdData_d;
  reg              sclOe_d;
  reg              sdaOe_d;
  reg              pready_d;
  reg              irq_d;
  // first period uses six reload bits, the later ones seven; widened on purpose
  wire [CNT_W-1:0] loadShort = {{(CNT_W-6){1'b0}}, reload_q[5:0]};
  wire [CNT_W-1:0] loadLong  = reload_q[CNT_W-1:0];

  // sequencer and baud counter
  always @* begin
    state_d   = state_q;
    baud_d    = baud_q;
    baudRun_d = baudRun_q;
    holdLow_d = holdLow_q;
    sdaLow_d  = sdaLow_q;
    if (baudRun_q && !expire)
      baud_d = baud_q - {{(CNT_W-1){1'b0}}, 1'b1};
    if (expire)
      baudRun_d = 1'b0;
    if (bcol) begin
      // a lost bus is left at once, both lines released
      state_d   = S_IDLE;
      baudRun_d = 1'b0;
      holdLow_d = 1'b0;
      sdaLow_d  = 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (rsReq) begin
            state_d   = S_SCLL;
            holdLow_d = 1'b1;
            sdaLow_d  = 1'b0;
          end
        end
        S_SCLL: begin
          if (!sclS) begin
            baud_d    = loadShort;
            baudRun_d = 1'b1;
            state_d   = S_REL;
          end
        end
        S_REL: begin
          // a data line held low by someone else keeps the clock low here
          if (expire && sdaS) begin
            holdLow_d = 1'b0;
            state_d   = S_SCLH;
          end
        end
        S_SCLH: begin
          if (sclS) begin
            baud_d    = loadLong;
            baudRun_d = 1'b1;
            state_d   = S_HIGH;
          end
        end
        S_HIGH: begin
          if (expire && sclS && sdaS) begin
            sdaLow_d  = 1'b1;
            baud_d    = loadLong;
            baudRun_d = 1'b1;
            state_d   = S_SDAL;
          end
        end
        S_SDAL: begin
          if (expire)
            state_d = S_IDLE;
        end
        default: state_d = S_IDLE;
      endcase
    end
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_q   <= S_IDLE;
      baud_q    <= {CNT_W{1'b0}};
      baudRun_q <= 1'b0;
      holdLow_q <= 1'b0;
      sdaLow_q  <= 1'b0;
    end else begin
      state_q   <= state_d;
      baud_q    <= baud_d;
      baudRun_q <= baudRun_d;
      holdLow_q <= holdLow_d;
      sdaLow_q  <= sdaLow_d;
    end
  end

  // output next values; every output leaves the block from a flop
  always @* begin
    sclOe_d  = holdLow_q;
    sdaOe_d  = sdaLow_q;
    // pready rises in the access cycle, so the slave never adds wait states
    pready_d = psel & ~penable;
    irq_d    = |(irqStat_q & irqMask_q);
  end

  // pin drivers: open drain, only ever pull low
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sclOut <= 1'b1;
      sclOe  <= 1'b0;
      sdaOut <= 1'b1;
      sdaOe  <= 1'b0;
    end else begin
      sclOut <= 1'b0;
      sclOe  <= sclOe_d;
      sdaOut <= 1'b0;
      sdaOe  <= sdaOe_d;
    end
  end

  // registers
  always @* begin
    buf_d     = buf_q;
    reload_d  = reload_q;
    maskAdr_d = maskAdr_q;
    ctrl1_d   = ctrl1_q;
    ctrl2_d   = ctrl2_q;
    start_d   = start_q;
    irqStat_d = irqStat_q;
    irqMask_d = irqMask_q;
    if (wrEn) begin
      case (paddr)
        `IRS_OFF_BUF: begin
          if (!busy)
            buf_d = pwdata[7:0];
        end
        `IRS_OFF_RELOAD: begin
          reload_d = pwdata[7:0];
        end
        `IRS_OFF_MASKADR: begin
          maskAdr_d = pwdata[7:0];
        end
        `IRS_OFF_CTRL1: begin
          ctrl1_d = pwdata[7:0];
        end
        `IRS_OFF_CTRL2: begin
          // no queued bus events: the low bits wait until the sequence is over
          if (busy)
            ctrl2_d = (ctrl2_q & `IRS_CTRL2_LOWMSK) | (pwdata[7:0] & ~`IRS_CTRL2_LOWMSK);
          else
            ctrl2_d = pwdata[7:0];
        end
        `IRS_OFF_IRQMASK: begin
          irqMask_d = pwdata[2:0];
        end
        default: ;
      endcase
    end
    if (doneEv || bcol)
      ctrl2_d[`IRS_CTRL2_REPEATED_START_REQUEST] = 1'b0;
    // set wins over the clear
    if (wcolEv)
      ctrl1_d[`IRS_CTRL1_WRITE_COLLISION_FLAG] = 1'b1;
    if (startSeen)
      start_d = 1'b1;
    else if (wrEn && paddr == `IRS_OFF_STATUS && !pwdata[`IRS_STAT_START])
      start_d = 1'b0;
    irqStat_d = (irqStat_q & ~irqClr) | irqSet;
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      buf_q     <= `IRS_RST_BYTE;
      reload_q  <= `IRS_RST_RELOAD;
      maskAdr_q <= `IRS_RST_BYTE;
      ctrl1_q   <= `IRS_RST_BYTE;
      ctrl2_q   <= `IRS_RST_BYTE;
      start_q   <= 1'b0;
      irqStat_q <= 3'h0;
      irqMask_q <= 3'h0;
    end else begin
      buf_q     <= buf_d;
      reload_q  <= reload_d;
      maskAdr_q <= maskAdr_d;
      ctrl1_q   <= ctrl1_d;
      ctrl2_q   <= ctrl2_d;
      start_q   <= start_d;
      irqStat_q <= irqStat_d;
      irqMask_q <= irqMask_d;
    end
  end

  // read data is chosen in the setup cycle so that it stands with pready
  always @* begin
    rdData_d = prdata;
    if (rdEn) begin
      case (paddr)
        `IRS_OFF_BUF:     rdData_d = {24'h0, buf_q};
        `IRS_OFF_RELOAD:  rdData_d = {24'h0, reload_q};
        `IRS_OFF_MASKADR: rdData_d = {24'h0, maskAdr_q};
        `IRS_OFF_CTRL1:   rdData_d = {24'h0, ctrl1_q};
        `IRS_OFF_CTRL2:   rdData_d = {24'h0, ctrl2_q};
        `IRS_OFF_STATUS:  rdData_d = {28'h0, start_q, 3'h0};
        `IRS_OFF_IRQSTAT: rdData_d = {29'h0, irqStat_q};
        `IRS_OFF_IRQMASK: rdData_d = {29'h0, irqMask_q};
        default:          rdData_d = 32'h0;
      endcase
    end
  end

  // apb: zero wait states, unmapped reads zero, never an error
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      irq     <= 1'b0;
    end else begin
      prdata  <= rdData_d;
      pready  <= pready_d;
      pslverr <= 1'b0;
      irq     <= irq_d;
    end
  end
endmodule // irs_repeated_start
`default_nettype wire

//--- irs_repeated_start_assertions.sv
// port checker for the repeated-start sequencer
// assumes irq mask bits 1:0 set while sequences run
`timescale 1ns/1ps
`default_nettype none
`include "irs_defs.vh"
module irs_repeated_start_assertions (
  input wire logic        clk_sys, sys_rst, psel, penable, pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready, sclIn, sclOe, sdaIn, sdaOe, irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [3:0] wrAge;
  logic       seqOn;
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst) begin
      wrAge <= 4'hF;
      seqOn <= 1'h0;
    end else begin
      if (psel && penable && pwrite && paddr == `IRS_OFF_CTRL2 && pwdata[1]) wrAge <= 4'h0;
      else if (wrAge != 4'hF) wrAge <= wrAge + 4'h1;
      // collisions only count between clock pull and data drive
      seqOn <= $rose(sclOe) || (seqOn && !irq && !$rose(sdaOe));
    end
  property p_start; $rose(sclOe) |-> wrAge <= 4'h6; endproperty
  a_start: assert property (p_start) else $error("clock pulled unasked");
  property p_rel; $fell(sclOe) |-> $past(sdaIn, 3); endproperty
  a_rel: assert property (p_rel) else $error("clock freed, data low");
  property p_drive; $rose(sdaOe) |-> sclIn && !sclOe; endproperty
  a_drive: assert property (p_drive) else $error("data driven, clock low");
  property p_hold; $rose(sdaOe) |=> sdaOe [*8]; endproperty
  a_hold: assert property (p_hold) else $error("data not held");
  property p_irq; $rose(sdaOe) && !irq |=> (!$rose(irq)) [*8] ##[1:80] $rose(irq); endproperty
  a_irq: assert property (p_irq) else $error("irq timing");
  property p_colUp; seqOn && $rose(sclIn) && !sdaIn |-> ##[1:8] irq && !sclOe && !sdaOe; endproperty
  a_colUp: assert property (p_colUp) else $error("rise collision missed");
  property p_colDn; seqOn && $fell(sclIn) && !sclOe && !sdaOe |-> ##[1:8] irq && !sclOe; endproperty
  a_colDn: assert property (p_colDn) else $error("fall collision missed");
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
endmodule // irs_repeated_start_assertions
bind irs_repeated_start irs_repeated_start_assertions irs_repeated_start_assertions_i (.clk_sys, .sys_rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .sclIn, .sclOe, .sdaIn, .sdaOe, .irq);
`default_nettype wire

//--- test_irs_repeated_start.sv
// self-checking bench for the repeated-start sequencer
// takes apb answers after any number of wait states; assumes pull-ups on both lines
`timescale 1ns/1ps
`default_nettype none
`include "irs_defs.vh"
module test_irs_repeated_start;
  typedef struct {logic [7:0] a; logic [31:0] d, e;} irs_row_t;
  irs_row_t rows [5] = '{'{`IRS_OFF_RELOAD, 32'hFF45, 32'h45}, '{`IRS_OFF_MASKADR, 32'h1A5, 32'hA5},
    '{`IRS_OFF_BUF, 32'h3C, 32'h3C}, '{8'h40, 32'h55, 32'h0}, '{`IRS_OFF_IRQMASK, 32'h7, 32'h7}};
  logic clk_sys = 1'h0, sys_rst = 1'h1, linkClk = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic holdSda = 1'h0, pullScl = 1'h0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, rd;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, sclOut, sdaOut, sclOe, sdaOe, irq, sclIn, sdaIn;
  wire logic [2:0] obs = {irq, sdaOe, sclOe};
  int error_cnt = 0, checks_done = 0, n;
  irs_repeated_start irs_repeated_start_i (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sclIn, .sclOut, .sclOe, .sdaIn, .sdaOut, .sdaOe, .irq);
  irs_bus_partner irs_bus_partner_i (.linkClk, .sclOe, .sdaOe, .holdSda, .pullScl, .sclLine(sclIn), .sdaLine(sdaIn));
  initial forever #50 clk_sys = ~clk_sys;
  initial forever #400 linkClk = ~linkClk;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge clk_sys);
    penable <= 1'h1;
    // no wait-state count is assumed; only the watchdog ends a stuck wait
    @(posedge clk_sys);
    while (pready !== 1'h1) @(posedge clk_sys);
    rd = prdata;
    {psel, penable} <= 2'h0;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd & m, e);
  endtask
  // counts cycles into n; a hang shows up as a failed compare
  task waitSig(input int b, input logic v);
    for (n = 0; obs[b] !== v && n < 600; n++) @(posedge clk_sys);
    chk(n < 600, 1'h1);
  endtask
  task chkIrq(input logic e);
    repeat (2) @(posedge clk_sys);
    chk(irq, e);
  endtask
  task final_report;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #500us;
    error_cnt++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'h0;
    rc(`IRS_OFF_RELOAD, 32'hFF, `IRS_RST_RELOAD);
    foreach (rows[i]) begin
      apb(1'h1, rows[i].a, rows[i].d);
      rc(rows[i].a, 32'hFFFFFFFF, rows[i].e);
    end
    apb(1'h1, `IRS_OFF_CTRL2, 32'h2);
    waitSig(0, 1'h1);
    waitSig(0, 1'h0);
    chk(n < 20, 1'h1);
    waitSig(1, 1'h1);
    chk(n inside {[70:76]}, 1'h1);
    waitSig(2, 1'h1);
    chk(n inside {[69:72]}, 1'h1);
    chk(sdaOe, 1'h1);
    rc(`IRS_OFF_CTRL2, 32'hFF, 32'h0);
    rc(`IRS_OFF_STATUS, 32'h8, 32'h8);
    apb(1'h1, `IRS_OFF_IRQMASK, 32'h0);
    chkIrq(1'h0);
    apb(1'h1, `IRS_OFF_IRQMASK, 32'h7);
    chkIrq(1'h1);
    apb(1'h1, `IRS_OFF_IRQSTAT, 32'h7);
    chkIrq(1'h0);
    apb(1'h1, `IRS_OFF_BUF, 32'h5A);
    rc(`IRS_OFF_BUF, 32'hFF, 32'h5A);
    apb(1'h1, `IRS_OFF_CTRL2, 32'h2);
    apb(1'h1, `IRS_OFF_BUF, 32'h99);
    apb(1'h1, `IRS_OFF_CTRL2, 32'h1F);
    waitSig(1, 1'h0);
    waitSig(1, 1'h1);
    repeat (80) @(posedge clk_sys);
    rc(`IRS_OFF_BUF, 32'hFF, 32'h5A);
    rc(`IRS_OFF_CTRL1, 32'h80, 32'h80);
    rc(`IRS_OFF_CTRL2, 32'hFF, 32'h0);
    rc(`IRS_OFF_IRQSTAT, 32'hFF, 32'h5);
    apb(1'h1, `IRS_OFF_IRQSTAT, 32'h7);
    for (int k = 0; k < 2; k++) begin
      apb(1'h1, `IRS_OFF_CTRL2, 32'h2);
      waitSig(0, 1'h1);
      if (k == 1) waitSig(0, 1'h0);
      {pullScl, holdSda} <= (k == 1) ? 2'h2 : 2'h1;
      waitSig(2, 1'h1);
      chk(obs[1:0], 2'h0);
      rc(`IRS_OFF_IRQSTAT, 32'hFF, 32'h2);
      {pullScl, holdSda} <= 2'h0;
      repeat (20) @(posedge clk_sys);
      apb(1'h1, `IRS_OFF_IRQSTAT, 32'h7);
    end
    final_report;
  end
endmodule // test_irs_repeated_start
`default_nettype wire
